// [include/dxse_pkg.sv]
package dxse_pkg;
	// register map (byte addresses, one aligned word each)
	localparam logic [7:0]  ADDR_CMD    = 8'h00;
	localparam logic [7:0]  ADDR_XWD    = 8'h04;
	localparam logic [7:0]  ADDR_MEMOP  = 8'h08;
	localparam logic [7:0]  ADDR_MEMRES = 8'h0C;
	localparam logic [7:0]  ADDR_STATUS = 8'h10;
	localparam logic [7:0]  ADDR_PSW    = 8'h14;
	localparam logic [7:0]  ADDR_GPR    = 8'h40;
	localparam logic [7:0]  GPR_MASK    = 8'hC3;
	localparam int          GPR_COUNT   = 16;
	// status register bits
	localparam int          ST_BUSY     = 0;
	localparam int          ST_DONE     = 1;
	localparam int          ST_ZDIV     = 2;
	localparam int          ST_PRIV     = 3;
	localparam int          ST_ILL      = 4;
	localparam int          ST_OVF      = 5;
	// processor status word
	localparam int          PSW_C       = 0;
	localparam int          PSW_V       = 1;
	localparam int          PSW_Z       = 2;
	localparam int          PSW_N       = 3;
	localparam int          PSW_X       = 4;
	localparam int          PSW_S       = 13;
	localparam logic [15:0] PSW_RESET   = 16'h2700;
	localparam logic [15:0] PSW_IMPL    = 16'hE71F;
	localparam logic [7:0]  FLAG_IMPL   = 8'h1F;
	// operand sizes
	localparam logic [1:0]  SZ_BYTE     = 2'h0;
	localparam logic [1:0]  SZ_WORD     = 2'h1;
	localparam logic [1:0]  SZ_LONG     = 2'h2;
	// effective address encodings
	localparam logic [2:0]  EA_DREG     = 3'h0;
	localparam logic [2:0]  EA_AREG     = 3'h1;
	localparam logic [2:0]  EA_SPECIAL  = 3'h7;
	localparam logic [2:0]  EA_ABS_W    = 3'h0;
	localparam logic [2:0]  EA_ABS_L    = 3'h1;
	localparam logic [2:0]  EA_IMM      = 3'h4;
	// opcode patterns
	localparam logic [3:0]  OPG_DIVW    = 4'h8;
	localparam logic [2:0]  OPM_DIVW    = 3'h3;
	localparam logic [9:0]  OP_DIVL     = 10'h131;
	localparam int          XWD_SIGNED  = 11;
	localparam int          XWD_SIZE    = 10;
	localparam logic [3:0]  OPG_RXOR    = 4'hB;
	localparam logic [2:0]  OPM_XOR_B   = 3'h4;
	localparam logic [2:0]  OPM_XOR_L   = 3'h6;
	localparam logic [7:0]  OP_IXOR     = 8'h0A;
	localparam logic [7:0]  OP_IXOR_FLG = 8'h3C;
	localparam logic [7:0]  OP_IXOR_PSW = 8'h7C;
	localparam logic [3:0]  OPG_SWAP    = 4'hC;
	localparam logic [4:0]  SWAP_DD     = 5'h08;
	localparam logic [4:0]  SWAP_AA     = 5'h09;
	localparam logic [4:0]  SWAP_DA     = 5'h11;
	localparam logic [6:0]  OP_WIDEN    = 7'h24;
	localparam logic [2:0]  WIDEN_BW    = 3'h2;
	localparam logic [2:0]  WIDEN_WL    = 3'h3;
	localparam logic [2:0]  WIDEN_BL    = 3'h7;
	// divide limits and timing
	localparam logic [63:0] QUOT_W_MAX  = 64'h0000_0000_0000_7FFF;
	localparam logic [6:0]  DIV_STEPS   = 7'h40;
	typedef enum logic {DXSE_IDLE, DXSE_DIVIDE} dxse_state_type;
endpackage

// [src/dxse_divider.sv]
// restoring divider, one quotient bit per clock; 64 steps regardless of operands
module dxse_divider
	import dxse_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        start,
	input  wire logic [63:0] dividend,
	input  wire logic [31:0] divisor,
	output logic             done,
	output logic [63:0]      quotient,
	output logic [31:0]      remainder
);
	logic [6:0]  count_reg;
	logic [63:0] quot_reg;
	logic [31:0] rem_reg;
	logic [31:0] div_reg;
	logic        done_reg;
	logic [32:0] shifted;
	logic        fits;

	assign shifted = {rem_reg, quot_reg[63]};
	assign fits = shifted >= {1'b0, div_reg};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= '0;
			quot_reg  <= '0;
			rem_reg   <= '0;
			div_reg   <= '0;
			done_reg  <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			if (start) begin
				count_reg <= DIV_STEPS;
				quot_reg  <= dividend;
				rem_reg   <= '0;
				div_reg   <= divisor;
			end else if (count_reg != '0) begin
				count_reg <= count_reg - 7'h01;
				quot_reg  <= {quot_reg[62:0], fits};
				rem_reg   <= fits ? 32'(shifted - {1'b0, div_reg}) : shifted[31:0];
				done_reg  <= count_reg == 7'h01;
			end
		end
	end

	assign done      = done_reg;
	assign quotient  = quot_reg;
	assign remainder = rem_reg;
endmodule

// [src/dxse_core.sv]
// Operation
// - word divide overflows above signed 16-bit quotient
// - divide sets negative from quotient sign
// - divide sets overflow, clears carry, keeps extend
// - word divide register field is destination
// - divide source accepts data modes only
// - long divide quotient register gives low dividend
// - size bit picks 32 or 64 bit dividend
// - remainder written unless registers coincide
// - long divide overflows beyond 32-bit quotient
// - register xor, opmode picks byte/word/long
// - xor sets N,Z; clears V,C
// - xor destination only data alterable modes
// - no memory to register xor
// - immediate size selects extension data
// - immediate bits toggle matching flags
// - flag byte xor leaves upper byte
// - status word xor privileged, else trap
// - swap two full registers by opmode
// - mixed swap: data first, address second
// - sign widen replicates sign bit left
// - zero divisor raises trap
// - divide overflow leaves destinations unchanged
// - word quotient low, remainder high half
// - widen opmodes 010, 011, 111
module dxse_core
	import dxse_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             exc_zero_divide,
	output logic             exc_privilege,
	output logic             exc_illegal
);
	logic [31:0]          gpr_reg [0:GPR_COUNT-1];
	logic [15:0]          psw_reg;
	logic [31:0]          xwd_reg;
	logic [31:0]          memop_reg;
	logic [31:0]          memres_reg;
	logic [ST_OVF:ST_DONE] sticky_reg;
	dxse_state_type       state_reg;
	logic                 div_word_reg;
	logic [2:0]           div_dq_reg;
	logic [2:0]           div_rr_reg;
	logic                 pready_reg;
	logic                 pslverr_reg;
	logic [31:0]          prdata_reg;
	logic                 zdiv_reg;
	logic                 priv_reg;
	logic                 ill_reg;

	logic                 busy;
	logic                 setup;
	logic                 access;
	logic                 wr_ok;
	logic                 addr_gpr;
	logic [3:0]           gpr_idx;
	logic                 mapped;
	logic                 cmd_issue;
	logic [31:0]          rd_data;

	logic [15:0]          op;
	logic [2:0]           ea_mode;
	logic [2:0]           ea_reg;
	logic [2:0]           op_reg;
	logic [2:0]           op_mode;
	logic [15:0]          xwd_first;
	logic                 ea_data_ok;
	logic                 ea_alt_ok;
	logic [31:0]          ea_val;

	logic                 wa_en;
	logic [3:0]           wa_idx;
	logic [31:0]          wa_val;
	logic                 wb_en;
	logic [3:0]           wb_idx;
	logic [31:0]          wb_val;
	logic                 res_en;
	logic [31:0]          res_val;
	logic                 psw_en;
	logic [15:0]          psw_val;
	logic                 div_start;
	logic [63:0]          dividend;
	logic [31:0]          divisor;
	logic                 nx_word;
	logic [2:0]           nx_dq;
	logic [2:0]           nx_rr;
	logic                 ev_done;
	logic                 ev_zdiv;
	logic                 ev_priv;
	logic                 ev_ill;
	logic                 ev_ovf;
	logic                 div_done;
	logic [63:0]          div_quot;
	logic [31:0]          div_rem;
	logic [ST_OVF:ST_DONE] sticky_set;
	logic [ST_OVF:ST_DONE] sticky_clr;

	function automatic logic [31:0] merge_sized(input logic [31:0] old,
			input logic [31:0] val, input logic [1:0] sz);
		case (sz)
			SZ_BYTE: merge_sized = {old[31:8], val[7:0]};
			SZ_WORD: merge_sized = {old[31:16], val[15:0]};
			default: merge_sized = val;
		endcase
	endfunction

	function automatic logic [15:0] result_flags(input logic [15:0] psw,
			input logic [31:0] res, input logic [1:0] sz);
		logic [15:0] f;
		f = psw;
		case (sz)
			SZ_BYTE: begin
				f[PSW_N] = res[7];
				f[PSW_Z] = res[7:0] == '0;
			end
			SZ_WORD: begin
				f[PSW_N] = res[15];
				f[PSW_Z] = res[15:0] == '0;
			end
			default: begin
				f[PSW_N] = res[31];
				f[PSW_Z] = res == '0;
			end
		endcase
		f[PSW_V] = 1'b0;
		f[PSW_C] = 1'b0;
		result_flags = f;
	endfunction

	assign busy      = state_reg == DXSE_DIVIDE;
	assign setup     = psel & ~penable;
	assign access    = psel & penable & pready_reg;
	assign wr_ok     = access & pwrite & ~pslverr_reg;
	assign addr_gpr  = (paddr & GPR_MASK) == ADDR_GPR;
	assign gpr_idx   = paddr[5:2];
	assign mapped    = addr_gpr || paddr == ADDR_CMD || paddr == ADDR_XWD
		|| paddr == ADDR_MEMOP || paddr == ADDR_MEMRES || paddr == ADDR_STATUS
		|| paddr == ADDR_PSW;
	assign cmd_issue = wr_ok && paddr == ADDR_CMD;

	assign op        = pwdata[15:0];
	assign ea_mode   = op[5:3];
	assign ea_reg    = op[2:0];
	assign op_reg    = op[11:9];
	assign op_mode   = op[8:6];
	assign xwd_first = xwd_reg[31:16];
	assign ea_val    = ea_mode == EA_DREG ? gpr_reg[{1'b0, ea_reg}] : memop_reg;
	assign ea_data_ok = ea_mode != EA_AREG && (ea_mode != EA_SPECIAL || ea_reg <= EA_IMM);
	assign ea_alt_ok = ea_mode != EA_AREG
		&& (ea_mode != EA_SPECIAL || ea_reg == EA_ABS_W || ea_reg == EA_ABS_L);

	always_comb begin
		wa_en     = 1'b0;
		wa_idx    = '0;
		wa_val    = '0;
		wb_en     = 1'b0;
		wb_idx    = '0;
		wb_val    = '0;
		res_en    = 1'b0;
		res_val   = '0;
		psw_en    = 1'b0;
		psw_val   = psw_reg;
		div_start = 1'b0;
		dividend  = '0;
		divisor   = '0;
		nx_word   = 1'b0;
		nx_dq     = '0;
		nx_rr     = '0;
		ev_done   = 1'b0;
		ev_zdiv   = 1'b0;
		ev_priv   = 1'b0;
		ev_ill    = 1'b0;
		ev_ovf    = 1'b0;
		if (div_done) begin
			ev_done = 1'b1;
			psw_en  = 1'b1;
			psw_val[PSW_C] = 1'b0;
			if (div_word_reg ? div_quot > QUOT_W_MAX : div_quot[63:32] != '0) begin
				ev_ovf = 1'b1;
				psw_val[PSW_V] = 1'b1;
			end else if (div_word_reg) begin
				wa_en  = 1'b1;
				wa_idx = {1'b0, div_dq_reg};
				wa_val = {div_rem[15:0], div_quot[15:0]};
				psw_val = result_flags(psw_reg, div_quot[31:0], SZ_WORD);
			end else begin
				wa_en  = 1'b1;
				wa_idx = {1'b0, div_dq_reg};
				wa_val = div_quot[31:0];
				wb_en  = div_rr_reg != div_dq_reg;
				wb_idx = {1'b0, div_rr_reg};
				wb_val = div_rem;
				psw_val = result_flags(psw_reg, div_quot[31:0], SZ_LONG);
			end
		end else if (cmd_issue) begin
			ev_done = 1'b1;
			if (op[15:12] == OPG_DIVW && op_mode == OPM_DIVW) begin
				if (!ea_data_ok) begin
					ev_ill = 1'b1;
				end else if (ea_val[15:0] == '0) begin
					ev_zdiv = 1'b1;
				end else begin
					div_start = 1'b1;
					nx_word   = 1'b1;
					nx_dq     = op_reg;
					dividend  = {32'h0000_0000, gpr_reg[{1'b0, op_reg}]};
					divisor   = {16'h0000, ea_val[15:0]};
					ev_done   = 1'b0;
				end
			end else if (op[15:6] == OP_DIVL) begin
				if (!ea_data_ok || xwd_first[XWD_SIGNED]) begin
					ev_ill = 1'b1;
				end else if (ea_val == '0) begin
					ev_zdiv = 1'b1;
				end else begin
					div_start = 1'b1;
					nx_dq     = xwd_first[14:12];
					nx_rr     = xwd_first[2:0];
					dividend  = xwd_first[XWD_SIZE]
						? {gpr_reg[{1'b0, xwd_first[2:0]}], gpr_reg[{1'b0, xwd_first[14:12]}]}
						: {32'h0000_0000, gpr_reg[{1'b0, xwd_first[14:12]}]};
					divisor   = ea_val;
					ev_done   = 1'b0;
				end
			end else if (op[15:12] == OPG_RXOR && op_mode >= OPM_XOR_B
					&& op_mode <= OPM_XOR_L) begin
				if (!ea_alt_ok) begin
					ev_ill = 1'b1;
				end else begin
					res_val = merge_sized(ea_val, ea_val ^ gpr_reg[{1'b0, op_reg}],
						op_mode[1:0]);
					wa_en   = ea_mode == EA_DREG;
					wa_idx  = {1'b0, ea_reg};
					wa_val  = res_val;
					res_en  = ea_mode != EA_DREG;
					psw_en  = 1'b1;
					psw_val = result_flags(psw_reg, res_val, op_mode[1:0]);
				end
			end else if (op == {OP_IXOR, OP_IXOR_FLG}) begin
				psw_en  = 1'b1;
				psw_val = {psw_reg[15:8], psw_reg[7:0] ^ (xwd_first[7:0] & FLAG_IMPL)};
			end else if (op == {OP_IXOR, OP_IXOR_PSW}) begin
				if (psw_reg[PSW_S]) begin
					psw_en  = 1'b1;
					psw_val = psw_reg ^ (xwd_first & PSW_IMPL);
				end else begin
					ev_priv = 1'b1;
				end
			end else if (op[15:8] == OP_IXOR && op[7:6] != 2'h3) begin
				if (!ea_alt_ok) begin
					ev_ill = 1'b1;
				end else begin
					case (op[7:6])
						SZ_BYTE: res_val = ea_val ^ {24'h00_0000, xwd_first[7:0]};
						SZ_WORD: res_val = ea_val ^ {16'h0000, xwd_first};
						default: res_val = ea_val ^ xwd_reg;
					endcase
					res_val = merge_sized(ea_val, res_val, op[7:6]);
					wa_en   = ea_mode == EA_DREG;
					wa_idx  = {1'b0, ea_reg};
					wa_val  = res_val;
					res_en  = ea_mode != EA_DREG;
					psw_en  = 1'b1;
					psw_val = result_flags(psw_reg, res_val, op[7:6]);
				end
			end else if (op[15:12] == OPG_SWAP && (op[7:3] == SWAP_DD
					|| op[7:3] == SWAP_AA || op[7:3] == SWAP_DA)) begin
				// first field data unless both address
				wa_en  = 1'b1;
				wa_idx = {op[7:3] == SWAP_AA, op_reg};
				wb_en  = 1'b1;
				wb_idx = {op[7:3] != SWAP_DD, ea_reg};
				wa_val = gpr_reg[wb_idx];
				wb_val = gpr_reg[wa_idx];
			end else if (op[15:9] == OP_WIDEN && ea_mode == EA_DREG
					&& (op_mode == WIDEN_BW || op_mode == WIDEN_WL
					|| op_mode == WIDEN_BL)) begin
				wa_en  = 1'b1;
				wa_idx = {1'b0, ea_reg};
				res_val = gpr_reg[{1'b0, ea_reg}];
				case (op_mode)
					WIDEN_BW: wa_val = {res_val[31:16], {8{res_val[7]}}, res_val[7:0]};
					WIDEN_WL: wa_val = {{16{res_val[15]}}, res_val[15:0]};
					default:  wa_val = {{24{res_val[7]}}, res_val[7:0]};
				endcase
				res_val = '0;
				psw_en  = 1'b1;
				psw_val = result_flags(psw_reg, wa_val,
					op_mode == WIDEN_BW ? SZ_WORD : SZ_LONG);
			end else begin
				ev_ill = 1'b1;
			end
		end
	end

	dxse_divider u_divider (
		.pclk      (pclk),
		.presetn   (presetn),
		.start     (div_start),
		.dividend  (dividend),
		.divisor   (divisor),
		.done      (div_done),
		.quotient  (div_quot),
		.remainder (div_rem)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg    <= DXSE_IDLE;
			div_word_reg <= 1'b0;
			div_dq_reg   <= '0;
			div_rr_reg   <= '0;
		end else begin
			case (state_reg)
				DXSE_IDLE: begin
					if (div_start) begin
						state_reg    <= DXSE_DIVIDE;
						div_word_reg <= nx_word;
						div_dq_reg   <= nx_dq;
						div_rr_reg   <= nx_rr;
					end
				end
				DXSE_DIVIDE: begin
					if (div_done) begin
						state_reg <= DXSE_IDLE;
					end
				end
				default: state_reg <= DXSE_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < GPR_COUNT; i++) begin
				gpr_reg[i] <= '0;
			end
		end else begin
			if (wr_ok && addr_gpr) begin
				gpr_reg[gpr_idx] <= pwdata;
			end
			if (wa_en) begin
				gpr_reg[wa_idx] <= wa_val;
			end
			if (wb_en) begin
				gpr_reg[wb_idx] <= wb_val;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			psw_reg <= PSW_RESET;
		end else if (psw_en) begin
			psw_reg <= psw_val;
		end else if (wr_ok && paddr == ADDR_PSW) begin
			psw_reg <= pwdata[15:0] & PSW_IMPL;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xwd_reg    <= '0;
			memop_reg  <= '0;
			memres_reg <= '0;
		end else begin
			if (wr_ok && paddr == ADDR_XWD) begin
				xwd_reg <= pwdata;
			end
			if (wr_ok && paddr == ADDR_MEMOP) begin
				memop_reg <= pwdata;
			end
			if (res_en) begin
				memres_reg <= res_val;
			end
		end
	end

	// a new event wins over a clear written in the same cycle
	assign sticky_set = {ev_ovf, ev_ill, ev_priv, ev_zdiv, ev_done};
	assign sticky_clr = (wr_ok && paddr == ADDR_STATUS) ? pwdata[ST_OVF:ST_DONE] : '0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sticky_reg <= '0;
			zdiv_reg   <= 1'b0;
			priv_reg   <= 1'b0;
			ill_reg    <= 1'b0;
		end else begin
			sticky_reg <= (sticky_reg & ~sticky_clr) | sticky_set;
			zdiv_reg   <= ev_zdiv;
			priv_reg   <= ev_priv;
			ill_reg    <= ev_ill;
		end
	end

	always_comb begin
		rd_data = '0;
		if (addr_gpr) begin
			rd_data = gpr_reg[gpr_idx];
		end else begin
			case (paddr)
				ADDR_XWD:    rd_data = xwd_reg;
				ADDR_MEMOP:  rd_data = memop_reg;
				ADDR_MEMRES: rd_data = memres_reg;
				ADDR_STATUS: rd_data = {26'h0, sticky_reg, busy};
				ADDR_PSW:    rd_data = {16'h0000, psw_reg};
				default:     rd_data = '0;
			endcase
		end
	end

	// single wait-free access; writes during a divide are refused so that
	// software cannot race the divider's result into the register file
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= '0;
		end else begin
			pready_reg  <= setup;
			pslverr_reg <= setup && (!mapped || paddr[1:0] != 2'h0
				|| (pwrite && (busy || paddr == ADDR_MEMRES)));
			prdata_reg  <= (setup && !pwrite) ? rd_data : '0;
		end
	end

	assign prdata          = prdata_reg;
	assign pready          = pready_reg;
	assign pslverr         = pslverr_reg;
	assign exc_zero_divide = zdiv_reg;
	assign exc_privilege   = priv_reg;
	assign exc_illegal     = ill_reg;
endmodule

// [verification/dxse_core_monitor.sv]
module dxse_core_monitor
	import dxse_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        exc_zero_divide,
	input wire logic        exc_privilege,
	input wire logic        exc_illegal
);
	timeunit 1ns;
	timeprecision 100ps;
	logic cmd_ok;
	logic any_exc;
	// a refused command write starts nothing, so it may not launch a trap
	assign cmd_ok = psel && penable && pready && pwrite && !pslverr && paddr == ADDR_CMD;
	assign any_exc = exc_zero_divide || exc_privilege || exc_illegal;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence access_s;
		psel && penable;
	endsequence
	ready_first_a: assert property (setup_s ##1 access_s |-> pready)
		else $error("no pready in first access cycle");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	ready_access_a: assert property (pready |-> psel && penable)
		else $error("pready outside access cycle");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not zero outside access");
	align_err_a: assert property (psel && penable && pready && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("unaligned access accepted");
	result_ro_a: assert property (pready && pwrite && paddr == ADDR_MEMRES |-> pslverr)
		else $error("result register accepted a write");
	zdiv_cause_a: assert property (exc_zero_divide |-> $past(cmd_ok))
		else $error("zero divide trap without command");
	priv_cause_a: assert property (exc_privilege |-> $past(cmd_ok))
		else $error("privilege trap without command");
	ill_cause_a: assert property (exc_illegal |-> $past(cmd_ok))
		else $error("illegal trap without command");
	exc_pulse_a: assert property (any_exc |=> !any_exc)
		else $error("trap pulse longer than one cycle");
endmodule

bind dxse_core dxse_core_monitor i_dxse_core_monitor (
	.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.exc_zero_divide(exc_zero_divide), .exc_privilege(exc_privilege), .exc_illegal(exc_illegal)
);

// [verification/dxse_apb_host.sv]
module dxse_apb_host (
	input  wire logic        pclk,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	output logic [7:0]       paddr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [31:0]      pwdata
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines must not keep showing the last value
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule

// [verification/divide_xor_swap_extend_tb.sv]
module divide_xor_swap_extend_tb
	import dxse_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        pclk;
	logic        presetn;
	logic [7:0]  paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        exc_zero_divide;
	logic        exc_privilege;
	logic        exc_illegal;
	int          n_errors = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	int          n_zdiv = 0;
	int          n_priv = 0;
	int          n_ill = 0;
	int          n;
	logic [31:0] st;
	logic [31:0] v;
	logic        er;
	dxse_core i_dxse_core (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .exc_zero_divide(exc_zero_divide), .exc_privilege(exc_privilege),
		.exc_illegal(exc_illegal));
	dxse_apb_host i_dxse_apb_host (.pclk(pclk), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		n_zdiv <= n_zdiv + int'(exc_zero_divide === 1'b1);
		n_priv <= n_priv + int'(exc_privilege === 1'b1);
		n_ill <= n_ill + int'(exc_illegal === 1'b1);
		if (cycles == 20000) begin
			n_errors++;
			final_report();
		end
	end
	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		samples_checked++;
		if (got !== ex) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		i_dxse_apb_host.xfer(1'b1, a, d, v, er);
	endtask
	task setr(input int i, input logic [31:0] d);
		wr(ADDR_GPR + 8'(4 * i), d);
	endtask
	task chkr(input string nm, input int i, input logic [31:0] ex);
		i_dxse_apb_host.xfer(1'b0, ADDR_GPR + 8'(4 * i), 32'h0, v, er);
		chk(nm, ex, v);
	endtask
	task chkf(input string nm, input logic [15:0] ex);
		i_dxse_apb_host.xfer(1'b0, ADDR_PSW, 32'h0, v, er);
		chk(nm, 32'(ex), 32'(v[15:0]));
	endtask
	task poll();
		n = 0;
		do begin
			i_dxse_apb_host.xfer(1'b0, ADDR_STATUS, 32'h0, st, er);
			n++;
		end while (st[ST_BUSY] !== 1'b0 && n < 100);
		chk("busy cleared", 32'h0, 32'(st[ST_BUSY]));
		wr(ADDR_STATUS, 32'h0000_003E);
	endtask
	task run(input logic [15:0] op, input logic [31:0] xwd);
		wr(ADDR_XWD, xwd);
		wr(ADDR_CMD, 32'(op));
		poll();
	endtask
	task t_divide();
		setr(0, 32'd100);
		setr(1, 32'd7);
		wr(ADDR_PSW, 32'h0000_2711);
		wr(ADDR_CMD, 32'h0000_80C1);
		wr(ADDR_GPR, 32'h0);
		chk("busy write refused", 32'h1, 32'(er));
		poll();
		chk("done", 32'h1, 32'(st[ST_DONE]));
		chkr("word result", 0, 32'h0002_000E);
		chkf("divide flags", 16'h2710);
		setr(2, 32'h0000_8000);
		setr(1, 32'd1);
		run(16'h84C1, 32'h0);
		chk("overflow", 32'h1, 32'(st[ST_OVF]));
		chkr("overflow dest", 2, 32'h0000_8000);
		chkf("overflow flags", 16'h2712);
		setr(2, 32'h0000_7FFF);
		run(16'h84C1, 32'h0);
		chkr("largest quotient", 2, 32'h0000_7FFF);
		setr(0, 32'd100);
		wr(ADDR_MEMOP, 32'd10);
		run(16'h80FC, 32'h0);
		chkr("immediate source", 0, 32'h0000_000A);
		setr(1, 32'h0);
		run(16'h80C1, 32'h0);
		chk("zero divisor", 32'h1, 32'(st[ST_ZDIV]));
		chkr("zero divisor dest", 0, 32'h0000_000A);
		chk("zero divide trap", 32'h1, 32'(n_zdiv));
		$display("t_divide done");
	endtask
	task t_long();
		setr(1, 32'd2);
		setr(3, 32'h0);
		setr(4, 32'd1);
		run(16'h4C41, 32'h3404_0000);
		chkr("long quotient", 3, 32'h8000_0000);
		chkr("long remainder", 4, 32'h0);
		chkf("negative quotient", 16'h2718);
		setr(1, 32'd3);
		setr(3, 32'd10);
		setr(4, 32'd5);
		run(16'h4C41, 32'h3004_0000);
		chkr("short dividend", 3, 32'd3);
		chkr("short remainder", 4, 32'd1);
		setr(3, 32'd10);
		run(16'h4C41, 32'h3003_0000);
		chkr("quotient only", 3, 32'd3);
		setr(3, 32'h0);
		setr(4, 32'd3);
		run(16'h4C41, 32'h3404_0000);
		chk("long overflow", 32'h1, 32'(st[ST_OVF]));
		chkr("long overflow dest", 4, 32'd3);
		setr(3, 32'hFFFF_FFFF);
		setr(4, 32'd2);
		run(16'h4C41, 32'h3404_0000);
		chkr("largest long quotient", 3, 32'hFFFF_FFFF);
		$display("t_long done");
	endtask
	logic [31:0] msk [3] = '{32'h0000_00FF, 32'h0000_FFFF, 32'hFFFF_FFFF};
	logic [31:0] imx [3] = '{32'h1234_564C, 32'h1234_444C, 32'h0};
	logic [15:0] imf [3] = '{16'h2710, 16'h2710, 16'h2714};
	task t_xor();
		for (int k = 0; k < 3; k++) begin
			setr(5, 32'h1234_5678);
			setr(6, 32'h8080_8080);
			run(16'hBD05 + 16'(k * 64), 32'h0);
			chkr("register xor", 5, 32'h1234_5678 ^ (32'h8080_8080 & msk[k]));
			chkf("register xor flags", 16'h2718);
			setr(7, 32'h1234_5678);
			run(16'h0A07 + 16'(k * 64), 32'h1234_5678);
			chkr("immediate xor", 7, imx[k]);
			chkf("immediate xor flags", imf[k]);
		end
		wr(ADDR_MEMOP, 32'h1234_5678);
		run(16'hBD90, 32'h0);
		i_dxse_apb_host.xfer(1'b0, ADDR_MEMRES, 32'h0, v, er);
		chk("memory xor", 32'h1234_5678 ^ 32'h8080_8080, v);
		$display("t_xor done");
	endtask
	task t_flags();
		wr(ADDR_PSW, 32'h0000_2700);
		run(16'h0A3C, 32'hFFFF_0000);
		chkf("flag byte all", 16'h271F);
		run(16'h0A3C, 32'h0015_0000);
		chkf("flag byte some", 16'h270A);
		run(16'h0A7C, 32'h2001_0000);
		chkf("status word xor", 16'h070B);
		run(16'h0A7C, 32'h0001_0000);
		chk("user state trap", 32'h1, 32'(st[ST_PRIV]));
		chkf("user state keeps", 16'h070B);
		chk("privilege trap", 32'h1, 32'(n_priv));
		$display("t_flags done");
	endtask
	logic [15:0] sw [3] = '{16'hC141, 16'hC149, 16'hC189};
	int          ra [3] = '{0, 8, 0};
	int          rb [3] = '{1, 9, 9};
	logic [15:0] wo [3] = '{16'h4882, 16'h48C2, 16'h49C2};
	logic [31:0] wx [3] = '{32'h1234_FFF0, 32'hFFFF_80F0, 32'hFFFF_FFF0};
	task t_swap_widen();
		wr(ADDR_PSW, 32'h0000_2705);
		for (int k = 0; k < 3; k++) begin
			setr(ra[k], 32'hAAAA_0001);
			setr(rb[k], 32'h5555_0002);
			run(sw[k], 32'h0);
			chkr("swap first", ra[k], 32'h5555_0002);
			chkr("swap second", rb[k], 32'hAAAA_0001);
		end
		chkf("swap flags", 16'h2705);
		for (int k = 0; k < 3; k++) begin
			setr(2, 32'h1234_80F0);
			run(wo[k], 32'h0);
			chkr("widen", 2, wx[k]);
		end
		chkf("widen flags", 16'h2708);
		$display("t_swap_widen done");
	endtask
	logic [15:0] il [4] = '{16'h80C9, 16'hB948, 16'h0A7A, 16'hB010};
	task t_illegal();
		for (int k = 0; k < 4; k++) begin
			run(il[k], 32'h0);
			chk("illegal", 32'h1, 32'(st[ST_ILL]));
		end
		chk("illegal traps", 32'h4, 32'(n_ill));
		chkr("illegal keeps register", 0, 32'h5555_0002);
		chkf("illegal keeps flags", 16'h2708);
		wr(ADDR_MEMRES, 32'h1);
		chk("result write refused", 32'h1, 32'(er));
		i_dxse_apb_host.xfer(1'b0, 8'h41, 32'h0, v, er);
		chk("unaligned refused", 32'h1, 32'(er));
		$display("t_illegal done");
	endtask
	task final_report();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		presetn = 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_divide();
		t_long();
		t_xor();
		t_flags();
		t_swap_widen();
		t_illegal();
		final_report();
	end
endmodule
